// ### logic/cmid_pkg.sv
// Shared constants for the compute-and-move instruction decoder
package cmid_pkg;

  // Widths of the instruction word, data-path addresses and selects
  localparam int CMID_IW       = 48;
  localparam int CMID_AW       = 32;
  localparam int CMID_CW       = 23;
  localparam int CMID_IDX_W    = 4;
  localparam int CMID_SEL_W    = 3;
  localparam int CMID_REG_W    = 4;
  localparam int CMID_CONDITION_CODE_FIELD_W   = 5;
  localparam int CMID_FLAG_W   = 32;

  // Group field and its codes
  localparam int CMID_GRP_HI   = 47;
  localparam int CMID_GRP_LO   = 45;
  localparam logic [2:0] CMID_GRP_MOVE = 3'h1;
  localparam logic [2:0] CMID_GRP_MISC = 3'h0;

  // Dual-move layout
  localparam int CMID_DMD_BIT  = 44;
  localparam int CMID_DMI_HI   = 43;
  localparam int CMID_DMI_LO   = 41;
  localparam int CMID_DMM_HI   = 40;
  localparam int CMID_DMM_LO   = 38;
  localparam int CMID_PMD_BIT  = 37;
  localparam int CMID_DMR_HI   = 36;
  localparam int CMID_DMR_LO   = 33;
  localparam int CMID_PMI_HI   = 32;
  localparam int CMID_PMI_LO   = 30;
  localparam int CMID_PMM_HI   = 29;
  localparam int CMID_PMM_LO   = 27;
  localparam int CMID_PMR_HI   = 26;
  localparam int CMID_PMR_LO   = 23;
  localparam int CMID_CMP_HI   = 22;
  localparam int CMID_CMP_LO   = 0;

  // Conditional compute layout
  localparam int CMID_SUB_HI   = 44;
  localparam int CMID_SUB_LO   = 40;
  localparam logic [4:0] CMID_SUB_CONDITION_CODE_FIELD = 5'h01;
  localparam int CMID_CONDITION_CODE_FIELD_HI  = 37;
  localparam int CMID_CONDITION_CODE_FIELD_LO  = 33;
  localparam logic [CMID_CONDITION_CODE_FIELD_W-1:0] CMID_CONDITION_CODE_FIELD_TRUE = 5'h1F;

  // Encodings and reset values
  localparam logic       CMID_DIR_WRITE = 1'b1;
  localparam logic [2:0] CMID_BCST_SEL  = 3'h1;
  localparam logic       CMID_FIRST_ADDRESS_GENERATOR      = 1'b0;
  localparam logic       CMID_SECOND_ADDRESS_GENERATOR      = 1'b1;
  localparam logic [CMID_CW-1:0] CMID_CMP_NOP  = 23'h000000;
  localparam logic [CMID_AW-1:0] CMID_IDX_RST  = 32'h00000000;
  localparam logic [CMID_AW-1:0] CMID_Y_STEP   = 32'h00000001;

  // Pipeline stage holding a decoded word
  typedef enum logic [1:0] {
    CMID_ST_IDLE = 2'b00,
    CMID_ST_MOVE = 2'b01,
    CMID_ST_CONDITION_CODE_FIELD = 2'b10,
    CMID_ST_BAD  = 2'b11
  } cmid_stage_t;

endpackage

// ### logic/cmid_idx_file.sv
// Index and modify register store for both address generators
`timescale 1ns/1ps
`default_nettype none
module cmid_idx_file
  import cmid_pkg::*;
(
  input  wire logic                              clk,
  input  wire logic                              reset_n,
  input  wire logic [cmid_pkg::CMID_IDX_W-1:0]   rd_i_a,
  input  wire logic [cmid_pkg::CMID_IDX_W-1:0]   rd_m_a,
  input  wire logic [cmid_pkg::CMID_IDX_W-1:0]   rd_i_b,
  input  wire logic [cmid_pkg::CMID_IDX_W-1:0]   rd_m_b,
  output logic      [cmid_pkg::CMID_AW-1:0]      i_a_q,
  output logic      [cmid_pkg::CMID_AW-1:0]      m_a_q,
  output logic      [cmid_pkg::CMID_AW-1:0]      i_b_q,
  output logic      [cmid_pkg::CMID_AW-1:0]      m_b_q,
  input  wire logic                              wb_a_en,
  input  wire logic [cmid_pkg::CMID_IDX_W-1:0]   wb_a_addr,
  input  wire logic [cmid_pkg::CMID_AW-1:0]      wb_a_data,
  input  wire logic                              wb_b_en,
  input  wire logic [cmid_pkg::CMID_IDX_W-1:0]   wb_b_addr,
  input  wire logic [cmid_pkg::CMID_AW-1:0]      wb_b_data,
  input  wire logic                              ld_en,
  input  wire logic                              ld_modify,
  input  wire logic [cmid_pkg::CMID_IDX_W-1:0]   ld_addr,
  input  wire logic [cmid_pkg::CMID_AW-1:0]      ld_data
);
  import cmid_pkg::*;

  localparam int NREG = 1 << CMID_IDX_W;

  logic [CMID_AW-1:0] idx_r [NREG];
  logic [CMID_AW-1:0] mod_r [NREG];

  ////////////////////////////////////////////////////////////////////////////
  // Next index value seen by a read: write-first so back-to-back
  // post-modifies of one register chain without a stall
  function automatic logic [CMID_AW-1:0] idx_view(
    input logic [CMID_IDX_W-1:0] a,
    input logic [CMID_AW-1:0]    cur,
    input logic                  wa_en,
    input logic [CMID_IDX_W-1:0] wa,
    input logic [CMID_AW-1:0]    wad,
    input logic                  wb_en,
    input logic [CMID_IDX_W-1:0] wb,
    input logic [CMID_AW-1:0]    wbd,
    input logic                  l_en,
    input logic [CMID_IDX_W-1:0] la,
    input logic [CMID_AW-1:0]    ld);
    logic [CMID_AW-1:0] v;
    v = cur;
    if (l_en && la == a) v = ld;
    if (wb_en && wb == a) v = wbd;
    if (wa_en && wa == a) v = wad;
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register arrays; instruction write-back wins over a software load
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int k = 0; k < NREG; k++) begin
        idx_r[k] <= CMID_IDX_RST;
        mod_r[k] <= CMID_IDX_RST;
      end
    end else begin
      if (ld_en && ld_modify) mod_r[ld_addr] <= ld_data;
      if (ld_en && !ld_modify) idx_r[ld_addr] <= ld_data;
      if (wb_b_en) idx_r[wb_b_addr] <= wb_b_data;
      if (wb_a_en) idx_r[wb_a_addr] <= wb_a_data;
    end
  end

  // Registered read ports
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      i_a_q <= CMID_IDX_RST;
      i_b_q <= CMID_IDX_RST;
      m_a_q <= CMID_IDX_RST;
      m_b_q <= CMID_IDX_RST;
    end else begin
      i_a_q <= idx_view(rd_i_a, idx_r[rd_i_a], wb_a_en, wb_a_addr, wb_a_data,
                        wb_b_en, wb_b_addr, wb_b_data, ld_en && !ld_modify, ld_addr, ld_data);
      i_b_q <= idx_view(rd_i_b, idx_r[rd_i_b], wb_a_en, wb_a_addr, wb_a_data,
                        wb_b_en, wb_b_addr, wb_b_data, ld_en && !ld_modify, ld_addr, ld_data);
      m_a_q <= (ld_en && ld_modify && ld_addr == rd_m_a) ? ld_data : mod_r[rd_m_a];
      m_b_q <= (ld_en && ld_modify && ld_addr == rd_m_b) ? ld_data : mod_r[rd_m_b];
    end
  end

endmodule
`default_nettype wire

// ### logic/cmid_condition_code_field_eval.sv
// Condition test of one processing element against its own flags
`timescale 1ns/1ps
`default_nettype none
module cmid_condition_code_field_eval
  import cmid_pkg::*;
(
  input  wire logic [cmid_pkg::CMID_CONDITION_CODE_FIELD_W-1:0]  condition_code_field_code,
  input  wire logic [cmid_pkg::CMID_FLAG_W-1:0]  flags,
  output logic                                   condition_code_field_true
);
  import cmid_pkg::*;

  // The always-true code ignores the flags; others pick one flag bit
  always_comb begin
    condition_code_field_true = (condition_code_field_code == CMID_CONDITION_CODE_FIELD_TRUE) || flags[condition_code_field_code];
  end

endmodule
`default_nettype wire

// ### logic/cmid_decode.sv
// Decode and execute of the dual-move and conditional compute formats
`timescale 1ns/1ps
`default_nettype none
module cmid_decode
  import cmid_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  input  wire logic                          instr_valid,
  input  wire logic [cmid_pkg::CMID_IW-1:0]  instr_word,
  input  wire logic                          simd_enable,
  input  wire logic                          broadcast_read_idx1,
  input  wire logic                          broadcast_read_idx9,
  input  wire logic [cmid_pkg::CMID_FLAG_W-1:0] flags_x,
  input  wire logic [cmid_pkg::CMID_FLAG_W-1:0] flags_y,
  input  wire logic                          idx_load_en,
  input  wire logic                          idx_load_modify,
  input  wire logic [cmid_pkg::CMID_IDX_W-1:0] idx_load_addr,
  input  wire logic [cmid_pkg::CMID_AW-1:0]  idx_load_data,
  output logic                               dm_valid,
  output logic                               dm_write,
  output logic [cmid_pkg::CMID_AW-1:0]       dm_addr_x,
  output logic [cmid_pkg::CMID_AW-1:0]       dm_addr_y,
  output logic                               dm_y_en,
  output logic                               dm_broadcast,
  output logic [cmid_pkg::CMID_REG_W-1:0]    data_mem_regfile_sel,
  output logic                               pm_valid,
  output logic                               pm_write,
  output logic [cmid_pkg::CMID_AW-1:0]       pm_addr_x,
  output logic [cmid_pkg::CMID_AW-1:0]       pm_addr_y,
  output logic                               pm_y_en,
  output logic                               pm_broadcast,
  output logic [cmid_pkg::CMID_REG_W-1:0]    prog_mem_regfile_sel,
  output logic                               compute_valid,
  output logic [cmid_pkg::CMID_CW-1:0]       compute_op,
  output logic                               compute_en_x,
  output logic                               compute_en_y,
  output logic                               unsupported_instr
);
  import cmid_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Field helpers shared by both memory ports
  function automatic logic [CMID_AW-1:0] y_addr(input logic [CMID_AW-1:0] idx,
                                                input logic bcst);
    // Second element reads at index+1 with no modify unless broadcasting
    y_addr = bcst ? idx : idx + CMID_Y_STEP;
  endfunction

  function automatic logic [CMID_AW-1:0] post_mod(input logic [CMID_AW-1:0] idx,
                                                  input logic [CMID_AW-1:0] md);
    post_mod = idx + md;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Stage 0: classify the incoming word
  logic [2:0] grp;
  logic [4:0] sub;
  logic       is_move;
  logic       is_condition_code_field;

  assign grp     = instr_word[CMID_GRP_HI:CMID_GRP_LO];
  assign sub     = instr_word[CMID_SUB_HI:CMID_SUB_LO];
  assign is_move = instr_valid && grp == CMID_GRP_MOVE;
  assign is_condition_code_field = instr_valid && grp == CMID_GRP_MISC && sub == CMID_SUB_CONDITION_CODE_FIELD;

  cmid_stage_t stage_r;
  cmid_stage_t stage_nxt;

  always_comb begin
    if (is_move) stage_nxt = CMID_ST_MOVE;
    else if (is_condition_code_field) stage_nxt = CMID_ST_CONDITION_CODE_FIELD;
    else if (instr_valid) stage_nxt = CMID_ST_BAD;
    else stage_nxt = CMID_ST_IDLE;
  end

  // Index file addresses: data side in the first generator, program side
  // in the second, so the two accesses never contend for one port
  logic [CMID_SEL_W-1:0] data_mem_index_sel;
  logic [CMID_SEL_W-1:0] prog_mem_index_sel;
  logic [CMID_IDX_W-1:0] rd_dm_i;
  logic [CMID_IDX_W-1:0] rd_dm_m;
  logic [CMID_IDX_W-1:0] rd_pm_i;
  logic [CMID_IDX_W-1:0] rd_pm_m;

  assign data_mem_index_sel     = instr_word[CMID_DMI_HI:CMID_DMI_LO];
  assign prog_mem_index_sel     = instr_word[CMID_PMI_HI:CMID_PMI_LO];
  assign rd_dm_i = {CMID_FIRST_ADDRESS_GENERATOR, data_mem_index_sel};
  assign rd_dm_m = {CMID_FIRST_ADDRESS_GENERATOR, instr_word[CMID_DMM_HI:CMID_DMM_LO]};
  assign rd_pm_i = {CMID_SECOND_ADDRESS_GENERATOR, prog_mem_index_sel};
  assign rd_pm_m = {CMID_SECOND_ADDRESS_GENERATOR, instr_word[CMID_PMM_HI:CMID_PMM_LO]};

  ////////////////////////////////////////////////////////////////////////////
  // Stage 1 registers: decoded fields and the mode seen at take
  logic                    s1_dmd_r;
  logic                    s1_pmd_r;
  logic [CMID_REG_W-1:0]   s1_dmr_r;
  logic [CMID_REG_W-1:0]   s1_pmr_r;
  logic [CMID_IDX_W-1:0]   s1_dmi_r;
  logic [CMID_IDX_W-1:0]   s1_pmi_r;
  logic [CMID_CW-1:0]      s1_cmp_r;
  logic [CMID_CONDITION_CODE_FIELD_W-1:0]  s1_condition_code_field_r;
  logic                    s1_simd_r;
  logic                    s1_dbc_r;
  logic                    s1_pbc_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) stage_r <= CMID_ST_IDLE;
    else stage_r <= stage_nxt;
  end

  // Field capture; held between words so the outputs stay quiet
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_dmd_r  <= 1'b0;
      s1_pmd_r  <= 1'b0;
      s1_dmr_r  <= '0;
      s1_pmr_r  <= '0;
      s1_dmi_r  <= '0;
      s1_pmi_r  <= '0;
      s1_cmp_r  <= CMID_CMP_NOP;
      s1_condition_code_field_r <= CMID_CONDITION_CODE_FIELD_TRUE;
      s1_simd_r <= 1'b0;
      s1_dbc_r  <= 1'b0;
      s1_pbc_r  <= 1'b0;
    end else if (instr_valid) begin
      s1_dmd_r  <= instr_word[CMID_DMD_BIT];
      s1_pmd_r  <= instr_word[CMID_PMD_BIT];
      s1_dmr_r  <= instr_word[CMID_DMR_HI:CMID_DMR_LO];
      s1_pmr_r  <= instr_word[CMID_PMR_HI:CMID_PMR_LO];
      s1_dmi_r  <= rd_dm_i;
      s1_pmi_r  <= rd_pm_i;
      s1_cmp_r  <= instr_word[CMID_CMP_HI:CMID_CMP_LO];
      s1_condition_code_field_r <= instr_word[CMID_CONDITION_CODE_FIELD_HI:CMID_CONDITION_CODE_FIELD_LO];
      s1_simd_r <= simd_enable;
      // Broadcast applies only to the slot-1 index of each generator
      s1_dbc_r  <= broadcast_read_idx1 && data_mem_index_sel == CMID_BCST_SEL;
      s1_pbc_r  <= broadcast_read_idx9 && prog_mem_index_sel == CMID_BCST_SEL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Index store and condition tests
  logic [CMID_AW-1:0] dm_i_q;
  logic [CMID_AW-1:0] dm_m_q;
  logic [CMID_AW-1:0] pm_i_q;
  logic [CMID_AW-1:0] pm_m_q;
  logic               s1_move;
  logic               s1_condition_code_field;
  logic               condition_code_field_x;
  logic               condition_code_field_y;
  logic [CMID_AW-1:0] wb_dm_data;
  logic [CMID_AW-1:0] wb_pm_data;

  assign s1_move = stage_r == CMID_ST_MOVE;
  assign s1_condition_code_field = stage_r == CMID_ST_CONDITION_CODE_FIELD;
  // One update per instruction from the first element's modify value,
  // never the second element's zero modify
  assign wb_dm_data = post_mod(dm_i_q, dm_m_q);
  assign wb_pm_data = post_mod(pm_i_q, pm_m_q);

  cmid_idx_file u_idx (
    .clk       (clk),
    .reset_n   (reset_n),
    .rd_i_a    (rd_dm_i),
    .rd_m_a    (rd_dm_m),
    .rd_i_b    (rd_pm_i),
    .rd_m_b    (rd_pm_m),
    .i_a_q     (dm_i_q),
    .m_a_q     (dm_m_q),
    .i_b_q     (pm_i_q),
    .m_b_q     (pm_m_q),
    .wb_a_en   (s1_move),
    .wb_a_addr (s1_dmi_r),
    .wb_a_data (wb_dm_data),
    .wb_b_en   (s1_move),
    .wb_b_addr (s1_pmi_r),
    .wb_b_data (wb_pm_data),
    .ld_en     (idx_load_en),
    .ld_modify (idx_load_modify),
    .ld_addr   (idx_load_addr),
    .ld_data   (idx_load_data)
  );

  cmid_condition_code_field_eval u_condition_code_field_x (
    .condition_code_field_code (s1_condition_code_field_r),
    .flags     (flags_x),
    .condition_code_field_true (condition_code_field_x)
  );

  cmid_condition_code_field_eval u_condition_code_field_y (
    .condition_code_field_code (s1_condition_code_field_r),
    .flags     (flags_y),
    .condition_code_field_true (condition_code_field_y)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Memory port outputs; both ports issue in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dm_valid             <= 1'b0;
      dm_write             <= 1'b0;
      dm_addr_x            <= CMID_IDX_RST;
      dm_addr_y            <= CMID_IDX_RST;
      dm_y_en              <= 1'b0;
      dm_broadcast         <= 1'b0;
      data_mem_regfile_sel <= '0;
      pm_valid             <= 1'b0;
      pm_write             <= 1'b0;
      pm_addr_x            <= CMID_IDX_RST;
      pm_addr_y            <= CMID_IDX_RST;
      pm_y_en              <= 1'b0;
      pm_broadcast         <= 1'b0;
      prog_mem_regfile_sel <= '0;
    end else begin
      dm_valid <= s1_move;
      pm_valid <= s1_move;
      if (s1_move) begin
        dm_write  <= s1_dmd_r == CMID_DIR_WRITE;
        pm_write  <= s1_pmd_r == CMID_DIR_WRITE;
        dm_addr_x <= dm_i_q;
        pm_addr_x <= pm_i_q;
        dm_addr_y <= y_addr(dm_i_q, s1_dbc_r);
        pm_addr_y <= y_addr(pm_i_q, s1_pbc_r);
        // Complementary register takes part in dual mode, and also on a
        // broadcast read so both elements pick up the one word
        dm_y_en <= s1_simd_r || (s1_dbc_r && s1_dmd_r != CMID_DIR_WRITE);
        pm_y_en <= s1_simd_r || (s1_pbc_r && s1_pmd_r != CMID_DIR_WRITE);
        dm_broadcast         <= s1_dbc_r;
        pm_broadcast         <= s1_pbc_r;
        data_mem_regfile_sel <= s1_dmr_r;
        prog_mem_regfile_sel <= s1_pmr_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compute dispatch per element
  logic cmp_present;

  assign cmp_present = s1_cmp_r != CMID_CMP_NOP;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      compute_valid     <= 1'b0;
      compute_op        <= CMID_CMP_NOP;
      compute_en_x      <= 1'b0;
      compute_en_y      <= 1'b0;
      unsupported_instr <= 1'b0;
    end else begin
      compute_valid     <= s1_move || s1_condition_code_field;
      unsupported_instr <= stage_r == CMID_ST_BAD;
      if (s1_move) begin
        compute_op   <= s1_cmp_r;
        compute_en_x <= cmp_present;
        compute_en_y <= cmp_present && s1_simd_r;
      end else if (s1_condition_code_field) begin
        compute_op   <= s1_cmp_r;
        compute_en_x <= condition_code_field_x;
        compute_en_y <= s1_simd_r && condition_code_field_y;
      end else begin
        compute_en_x <= 1'b0;
        compute_en_y <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence move_taken;
    instr_valid && instr_word[CMID_GRP_HI:CMID_GRP_LO] == CMID_GRP_MOVE;
  endsequence

  sequence condition_code_field_taken;
    instr_valid && instr_word[CMID_GRP_HI:CMID_GRP_LO] == CMID_GRP_MISC
      && instr_word[CMID_SUB_HI:CMID_SUB_LO] == CMID_SUB_CONDITION_CODE_FIELD;
  endsequence

  AST_MOVE_BOTH_PORTS: assert property (
    move_taken |=> ##1 (dm_valid && pm_valid && compute_valid))
    else $error("dual move did not issue both accesses");

  AST_ADDR_UNMODIFIED: assert property (
    s1_move |=> (dm_addr_x == $past(dm_i_q) && pm_addr_x == $past(pm_i_q)))
    else $error("access address is not the unmodified index");

  AST_POST_UPDATE: assert property (
    s1_move && !idx_load_en ##1 (instr_valid && !s1_move && !idx_load_en
      && rd_dm_i == $past(s1_dmi_r)) |=> dm_i_q == $past(dm_addr_x, 1) + $past(dm_m_q, 2))
    else $error("index not advanced by its modify value");

  AST_Y_PLUS_ONE: assert property (
    dm_valid && !dm_broadcast |-> dm_addr_y == dm_addr_x + CMID_Y_STEP)
    else $error("second element address is not index plus one");

  AST_BCST_SAME_WORD: assert property (
    pm_valid && pm_broadcast |-> pm_addr_y == pm_addr_x)
    else $error("broadcast second element address differs");

  AST_BCST_LOAD_BOTH: assert property (
    dm_valid && dm_broadcast && !dm_write |-> dm_y_en && dm_addr_y == dm_addr_x)
    else $error("broadcast read did not load both elements");

  AST_CONDITION_CODE_FIELD_GATES: assert property (
    condition_code_field_taken ##1 (condition_code_field_x == 1'b0) |=> !compute_en_x && compute_valid)
    else $error("compute ran on false condition");

  AST_SISD_ONLY_X: assert property (
    (instr_valid && !simd_enable) |=> ##1 !compute_en_y
      && !(dm_valid && dm_y_en && !dm_broadcast) && !(pm_valid && pm_y_en && !pm_broadcast))
    else $error("second element active in single-element mode");

  AST_SIMD_INDEPENDENT: assert property (
    s1_condition_code_field && s1_simd_r |=> compute_en_y == $past(condition_code_field_y) && compute_en_x == $past(condition_code_field_x))
    else $error("element condition results not independent");

  AST_NOP_MOVES: assert property (
    s1_move && s1_cmp_r == CMID_CMP_NOP |=> !compute_en_x && !compute_en_y && dm_valid)
    else $error("empty compute field not treated as no-op");

  AST_SIMD_BOTH_COMPUTE: assert property (
    s1_move && s1_simd_r && cmp_present |=> compute_en_x && compute_en_y && dm_y_en && pm_y_en)
    else $error("dual move not run in both elements");

  AST_BAD_FLAGGED: assert property (
    instr_valid && !is_move && !is_condition_code_field |=> ##1 unsupported_instr && !dm_valid)
    else $error("other format was not flagged");

endmodule
`default_nettype wire

// ### tb/cmid_seq_model.sv
// Program sequencer model that hands fetched words to the decoder
`timescale 1ns/1ps
`default_nettype none
module cmid_seq_model (
  input  wire logic                         clk,
  input  wire logic                         reset_n,
  input  wire logic                         go,
  input  wire logic [cmid_pkg::CMID_IW-1:0] word,
  output logic                              instr_valid,
  output logic      [cmid_pkg::CMID_IW-1:0] instr_word
);
  import cmid_pkg::*;
  ////////////////////////////////////////
  // One word per request; between words the bus flips to junk so a stale word is never reused
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      instr_valid <= 1'b0;
      instr_word  <= '0;
    end else if (go) begin
      instr_valid <= 1'b1;
      instr_word  <= word;
    end else begin
      instr_valid <= 1'b0;
      instr_word  <= ~instr_word;
    end
  end
endmodule
`default_nettype wire

// ### tb/cmid_decode_tb.sv
// Self-checking bench for the compute-and-move instruction decoder
`timescale 1ns/1ps
`default_nettype none
module cmid_decode_tb;
  import cmid_pkg::*;
  logic                   clk, reset_n, go, instr_valid, simd_enable;
  logic                   broadcast_read_idx1, broadcast_read_idx9, idx_load_en, idx_load_modify;
  logic [CMID_IW-1:0]     word, instr_word;
  logic [CMID_FLAG_W-1:0] flags_x, flags_y;
  logic [CMID_IDX_W-1:0]  idx_load_addr;
  logic [CMID_AW-1:0]     idx_load_data, dm_addr_x, dm_addr_y, pm_addr_x, pm_addr_y;
  logic                   dm_valid, dm_write, dm_y_en, dm_broadcast;
  logic                   pm_valid, pm_write, pm_y_en, pm_broadcast;
  logic                   compute_valid, compute_en_x, compute_en_y, unsupported_instr;
  logic [CMID_REG_W-1:0]  data_mem_regfile_sel, prog_mem_regfile_sel;
  logic [CMID_CW-1:0]     compute_op;
  int                     error_cnt, cmp_count;

  cmid_decode u_dut (.*);
  cmid_seq_model u_seq (.*);

  // Free-running 40 MHz core clock
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  ////////////////////////////////////////
  // Compare, count and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Software load of one index or modify register
  task automatic ld(input logic m, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    idx_load_en <= 1'h1;
    idx_load_modify <= m;
    idx_load_addr <= a;
    idx_load_data <= d;
    @(posedge clk);
    idx_load_en <= 1'h0;
  endtask

  // Issue one word with its mode bits, then wait a bounded time for the answer pulse
  task automatic run(input logic [47:0] w, input logic s, input logic [1:0] b,
                     input logic [31:0] fx, input logic [31:0] fy);
    int k;
    @(posedge clk);
    go <= 1'h1;
    word <= w;
    simd_enable <= s;
    broadcast_read_idx1 <= b[0];
    broadcast_read_idx9 <= b[1];
    flags_x <= fx;
    flags_y <= fy;
    @(posedge clk);
    go <= 1'h0;
    for (k = 0; k < 8; k++) begin
      @(posedge clk);
      #1;
      if ((dm_valid | compute_valid | unsupported_instr) === 1'h1) break;
    end
    if (k == 8) begin
      error_cnt++;
      close_out();
    end
  endtask

  // Word builders for the two formats
  function automatic logic [47:0] mv(input logic dd, input logic [2:0] di, input logic [2:0] dm,
    input logic pd, input logic [3:0] dr, input logic [2:0] pi, input logic [2:0] pm,
    input logic [3:0] pr, input logic [22:0] c);
    return {3'h1, dd, di, dm, pd, dr, pi, pm, pr, c};
  endfunction

  function automatic logic [47:0] cc(input logic [4:0] cd, input logic [22:0] c);
    return {3'h0, 5'h01, 2'h0, cd, 10'h000, c};
  endfunction

  ////////////////////////////////////////
  // Main sequence
  initial begin
    {reset_n, go, simd_enable, broadcast_read_idx1, broadcast_read_idx9} = 5'h00;
    {idx_load_en, idx_load_modify, idx_load_addr, idx_load_data} = '0;
    {word, flags_x, flags_y} = '0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (20) @(posedge clk);
    reset_n <= 1'h1;
    ld(1'h0, 4'h0, 32'h100);
    ld(1'h1, 4'h1, 32'h4);
    ld(1'h0, 4'h8, 32'h200);
    ld(1'h1, 4'hA, 32'h10);
    ld(1'h0, 4'h1, 32'h40);
    ld(1'h0, 4'h9, 32'h80);
    // Single-element dual move: data write, program read
    run(mv(1'h1, 3'h0, 3'h1, 1'h0, 4'h5, 3'h0, 3'h2, 4'h4, 23'h123), 1'h0, 2'h0, 0, 0);
    chk({dm_valid, pm_valid}, 2'h3);
    chk({dm_write, pm_write}, 2'h2);
    chk(dm_addr_x, 32'h100);
    chk(pm_addr_x, 32'h200);
    chk({data_mem_regfile_sel, prog_mem_regfile_sel}, 8'h54);
    chk(compute_op, 23'h123);
    chk({compute_en_x, compute_en_y, dm_y_en}, 3'h4);
    // Same word in dual-element mode sees the post-modified index
    run(mv(1'h1, 3'h0, 3'h1, 1'h0, 4'h5, 3'h0, 3'h2, 4'h4, 23'h123), 1'h1, 2'h0, 0, 0);
    chk(dm_addr_x, 32'h104);
    chk(dm_addr_y, 32'h105);
    chk(pm_addr_x, 32'h210);
    chk(pm_addr_y, 32'h211);
    chk({dm_y_en, pm_y_en}, 2'h3);
    chk({compute_en_x, compute_en_y}, 2'h3);
    // No compute, index stepped once; broadcast bits do not touch slot 0
    run(mv(1'h0, 3'h0, 3'h0, 1'h1, 4'h3, 3'h0, 3'h0, 4'h6, 23'h0), 1'h0, 2'h3, 0, 0);
    chk(dm_addr_x, 32'h108);
    chk(pm_addr_x, 32'h220);
    chk({dm_valid, dm_write, pm_write}, 3'h5);
    chk({compute_en_x, compute_en_y}, 2'h0);
    chk({dm_broadcast, pm_broadcast, dm_y_en}, 3'h0);
    // Broadcast reads on both generators
    run(mv(1'h0, 3'h1, 3'h0, 1'h0, 4'h2, 3'h1, 3'h0, 4'h7, 23'h5), 1'h1, 2'h3, 0, 0);
    chk(dm_addr_x, 32'h40);
    chk(dm_addr_y, 32'h40);
    chk(pm_addr_y, 32'h80);
    chk({dm_broadcast, dm_y_en, pm_broadcast}, 3'h7);
    // Conditional compute across modes and element flags
    run(cc(5'h1F, 23'h7), 1'h0, 2'h0, 0, 0);
    chk({dm_valid, compute_op}, {1'h0, 23'h7});
    chk({compute_en_x, compute_en_y}, 2'h2);
    run(cc(5'h03, 23'h7), 1'h0, 2'h0, 0, 32'h8);
    chk({compute_en_x, compute_en_y}, 2'h0);
    run(cc(5'h03, 23'h7), 1'h1, 2'h0, 32'h8, 0);
    chk({compute_en_x, compute_en_y}, 2'h2);
    run(cc(5'h03, 23'h7), 1'h1, 2'h0, 0, 32'h8);
    chk({compute_en_x, compute_en_y}, 2'h1);
    // Any other group is refused
    run(48'h4000_0000_0000, 1'h0, 2'h0, 0, 0);
    chk({unsupported_instr, compute_valid, dm_valid}, 3'h4);
    // Move, one idle cycle, same move: the second must see the first's update
    @(posedge clk);
    go <= 1'h1;
    word <= mv(1'h0, 3'h0, 3'h1, 1'h0, 4'h1, 3'h0, 3'h2, 4'h1, 23'h0);
    @(posedge clk);
    go <= 1'h0;
    run(mv(1'h0, 3'h0, 3'h1, 1'h0, 4'h1, 3'h0, 3'h2, 4'h1, 23'h0), 1'h0, 2'h0, 0, 0);
    chk(dm_addr_x, 32'h10C);
    chk(pm_addr_x, 32'h230);
    close_out();
  end
endmodule
`default_nettype wire
